// File: design/sdpc_burst_step.sv
// Burst address sequencer for the two low address bits.
`timescale 1ns/1ps
`default_nettype none

module sdpc_burst_step (
  input wire logic [1:0] i_start,
  input wire logic [1:0] i_beat,
  input wire logic i_burst_mode,
  output logic [1:0] o_low
);

  // Linear order counts up and wraps; interleaved order flips start bits.
  always_comb begin
    if (i_burst_mode == sdpc_pkg::BURST_LINEAR) begin
      o_low = i_start + i_beat;
    end else begin
      o_low = i_start ^ i_beat;
    end
  end

endmodule : sdpc_burst_step

`default_nettype wire

// File: design/sdpc_pkg.sv
// Shared types and constants for the synchronous SRAM port control block.
`default_nettype none

package sdpc_pkg;

  // Burst order strap levels.
  localparam logic BURST_LINEAR = 1'b0;
  localparam logic BURST_INTERLEAVED = 1'b1;

  // Beats in one burst and the width of the beat count.
  localparam int BEATS = 4;
  localparam int BEAT_W = 2;

  // Values taken at reset.
  localparam logic [1:0] BEAT_RST = 2'h0;
  localparam logic DESEL_RST = 1'b1;

  // Operation held by the pipeline between edges.
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } sdpc_op_t;

  // Synchronous control pins sampled together on each recognised edge.
  typedef struct packed {
    logic chip_select_a_n;
    logic chip_select_b;
    logic chip_select_c_n;
    logic write_en_n;
    logic advance_or_load;
  } sdpc_ctl_t;

endpackage : sdpc_pkg

`default_nettype wire

// File: design/sdpc_port.sv
// Pin-level control of a flow-through synchronous burst SRAM port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Third chip select, active low, sampled on edge.
// - Output enable low lets data pins drive.
// - Tri-state in write data, first read after deselect, deselect.
// - Clock qualify high freezes pipeline state, not output drive.
// - Clock qualify high stretches cycle, never deselects.
// - Sleep input enters retention sleep, data kept.
// - Sleep held low or floating means normal.
// - Input data captured on the rising edge.
// - Read drives word addressed at previous edge.
// - Parity lanes follow data, gated per byte select.
// - Strap low linear, high or floating interleaved.
// - First chip select, active low, sampled together.
// - Write enable low starts write, high reads.
// - Advance steps burst counter, load takes address.
// - Write data captured at next edge, overlaps.
module sdpc_port #(
  parameter int ADDR_W = 18,
  parameter int LANES = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire sdpc_pkg::sdpc_ctl_t i_ctl,
  input wire logic [LANES-1:0] i_byte_write_select_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_clock_qualify_n,
  input wire logic i_output_enable_n,
  input wire logic i_sleep_request,
  input wire logic i_burst_mode,
  input wire logic [8*LANES-1:0] i_dq,
  input wire logic [LANES-1:0] i_parity_lanes,
  output logic [8*LANES-1:0] o_dq,
  output logic o_dq_oe,
  output logic [LANES-1:0] o_parity_lanes,
  output logic o_parity_oe,
  output logic o_sleeping
);

  localparam int DEPTH = 1 << ADDR_W;
  localparam int DW = 8 * LANES;

  ////////////////////////////////////////////////////////////////////////////
  // Storage and pipeline state.

  logic [DW-1:0] mem_d [DEPTH];
  logic [LANES-1:0] mem_p [DEPTH];

  sdpc_pkg::sdpc_op_t op_r, op_nxt;
  logic [ADDR_W-1:0] base_r, base_nxt;
  logic [1:0] beat_r, beat_nxt;
  logic desel_r, desel_nxt;
  logic rd_sel_r, rd_sel_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
  logic [LANES-1:0] wr_be_n_r, wr_be_n_nxt;
  logic [DW-1:0] dq_r, dq_nxt;
  logic [LANES-1:0] par_r, par_nxt;
  logic oe_r, oe_nxt;
  logic sleep_r, sleep_nxt;

  logic active;
  logic selected;
  logic [1:0] low_nxt;
  logic [ADDR_W-1:0] addr_nxt;

  // A sleep request or a high clock qualify leaves the edge unrecognised.
  assign active = !i_clock_qualify_n && !i_sleep_request;
  assign selected = !i_ctl.chip_select_a_n && i_ctl.chip_select_b
                    && !i_ctl.chip_select_c_n;

  // Low address bits of the access that the next state points at.
  sdpc_burst_step u_step (
    .i_start(base_nxt[1:0]),
    .i_beat(beat_nxt),
    .i_burst_mode(i_burst_mode),
    .o_low(low_nxt)
  );

  assign addr_nxt = {base_nxt[ADDR_W-1:2], low_nxt};

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and burst sequencing.

  // Load takes a fresh command; advance repeats the held one on the next beat.
  always_comb begin
    op_nxt = op_r;
    base_nxt = base_r;
    beat_nxt = beat_r;
    if (active) begin
      if (!i_ctl.advance_or_load) begin
        beat_nxt = sdpc_pkg::BEAT_RST;
        if (selected) begin
          op_nxt = i_ctl.write_en_n ? sdpc_pkg::OP_READ : sdpc_pkg::OP_WRITE;
          base_nxt = i_addr;
        end else begin
          op_nxt = sdpc_pkg::OP_IDLE;
        end
      end else begin
        beat_nxt = beat_r + 2'h1;
      end
    end
  end

  // Data phase bookkeeping, read launch and output drive.
  always_comb begin
    desel_nxt = desel_r;
    rd_sel_nxt = rd_sel_r;
    wr_pend_nxt = wr_pend_r;
    wr_addr_nxt = wr_addr_r;
    wr_be_n_nxt = wr_be_n_r;
    dq_nxt = dq_r;
    par_nxt = par_r;
    if (active) begin
      desel_nxt = (op_nxt == sdpc_pkg::OP_IDLE);
      // The first read after a deselected cycle keeps the pins quiet.
      rd_sel_nxt = (op_nxt == sdpc_pkg::OP_READ) && !desel_r;
      wr_pend_nxt = (op_nxt == sdpc_pkg::OP_WRITE);
      wr_addr_nxt = addr_nxt;
      wr_be_n_nxt = i_byte_write_select_n;
      if (op_nxt == sdpc_pkg::OP_READ) begin
        dq_nxt = mem_d[addr_nxt];
        par_nxt = mem_p[addr_nxt];
      end
    end
    // Drive follows output enable on every clock outside a sleep request, even while frozen.
    oe_nxt = rd_sel_nxt && !i_output_enable_n && !i_sleep_request;
    sleep_nxt = i_sleep_request;
  end

  // Control state registers.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      op_r <= sdpc_pkg::OP_IDLE;
      base_r <= '0;
      beat_r <= sdpc_pkg::BEAT_RST;
      desel_r <= sdpc_pkg::DESEL_RST;
      rd_sel_r <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      wr_be_n_r <= '1;
      dq_r <= '0;
      par_r <= '0;
      oe_r <= 1'b0;
      sleep_r <= 1'b0;
    end else begin
      op_r <= op_nxt;
      base_r <= base_nxt;
      beat_r <= beat_nxt;
      desel_r <= desel_nxt;
      rd_sel_r <= rd_sel_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_be_n_r <= wr_be_n_nxt;
      dq_r <= dq_nxt;
      par_r <= par_nxt;
      oe_r <= oe_nxt;
      sleep_r <= sleep_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array write in the data phase.

  // Each byte lane and its parity bit land only when that lane is selected.
  always_ff @(posedge i_clk) begin
    if (active && wr_pend_r) begin
      for (int i = 0; i < LANES; i++) begin
        if (!wr_be_n_r[i]) begin
          mem_d[wr_addr_r][8*i +: 8] <= i_dq[8*i +: 8];
          mem_p[wr_addr_r][i] <= i_parity_lanes[i];
        end
      end
    end
  end

  // Outputs straight from flip-flops; parity shares the data drive.
  assign o_dq = dq_r;
  assign o_parity_lanes = par_r;
  assign o_dq_oe = oe_r;
  assign o_parity_oe = oe_r;
  assign o_sleeping = sleep_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic [DW-1:0] rd_word;
  assign rd_word = mem_d[addr_nxt];

  a_write_tristate: assert property (
    active && !i_ctl.advance_or_load && selected && !i_ctl.write_en_n
    |=> !o_dq_oe && !o_parity_oe) else $error("pins driven in write data phase");

  a_deselect_quiet: assert property (
    active && !i_ctl.advance_or_load && i_ctl.chip_select_c_n
    |=> !o_dq_oe ##1 (!o_dq_oe || !$past(desel_r))) else $error("driven while deselected");

  a_oe_masks: assert property (
    i_output_enable_n |=> !o_dq_oe) else $error("drive while output enable high");

  a_freeze_state: assert property (
    i_clock_qualify_n |=> $stable(op_r) && $stable(beat_r) && $stable(base_r)
    && $stable(wr_pend_r)) else $error("state moved while clock disqualified");

  a_stretch_hold: assert property (
    i_clock_qualify_n && o_dq_oe && !i_output_enable_n && !i_sleep_request
    |=> o_dq_oe && $stable(o_dq)) else $error("stretched read lost its data");

  a_read_word: assert property (
    active && !i_ctl.advance_or_load && selected && i_ctl.write_en_n && !desel_r
    && !i_output_enable_n |=> o_dq_oe && o_dq == $past(rd_word)) else $error("read data wrong");

  a_sleep_quiet: assert property (
    i_sleep_request |=> o_sleeping && !o_dq_oe && $stable(op_r)) else $error("sleep not honoured");

  a_linear_step: assert property (
    active && i_ctl.advance_or_load |=> beat_r == 2'($past(beat_r) + 2'h1))
    else $error("burst counter did not advance");

  a_write_lane0: assert property (
    active && wr_pend_r && !wr_be_n_r[0]
    |=> mem_d[$past(wr_addr_r)][7:0] == $past(i_dq[7:0])
    && mem_p[$past(wr_addr_r)][0] == $past(i_parity_lanes[0])) else $error("lane 0 not written");

  c_read: cover property (active && !i_ctl.advance_or_load && selected
    && i_ctl.write_en_n ##1 o_dq_oe);
  c_write: cover property (active && wr_pend_r && !wr_be_n_r[0]);
  c_burst: cover property ((active && i_ctl.advance_or_load && op_r == sdpc_pkg::OP_READ) [*3]);
  c_freeze: cover property (o_dq_oe && i_clock_qualify_n ##1 o_dq_oe);

endmodule : sdpc_port

`default_nettype wire

// File: testbench/sdpc_ctrl_model.sv
// Memory controller model that drives commands, controls and write data.
`timescale 1ns/1ps
`default_nettype none

module sdpc_ctrl_model (
  input wire logic i_clk,
  output var sdpc_pkg::sdpc_ctl_t o_ctl,
  output logic [5:0] o_addr,
  output logic [3:0] o_be_n,
  output logic o_oe_n,
  output logic o_qual_n,
  output logic o_sleep,
  output logic [35:0] o_wd
);
  // Codes: deselect, read, write, advance with first and second selects off, two more deselects.
  logic [4:0] codes [6] = '{5'h1a, 5'h0a, 5'h08, 5'h13, 5'h02, 5'h0e};
  logic [35:0] pend = 36'h0;
  logic pw = 1'b0;
  int mop = 0;
  ////////////////////////////////////////////////////////////
  // Idle levels from time zero; sleep stays low for normal work.
  initial begin
    o_ctl = sdpc_pkg::sdpc_ctl_t'(codes[0]);
    o_addr = 6'h0;
    o_be_n = 4'hf;
    o_oe_n = 1'b0;
    o_qual_n = 1'b0;
    o_sleep = 1'b0;
    o_wd = 36'h0;
  end
  // Pins change just after an edge; a held edge leaves the command in place.
  task automatic issue(input int k, input logic [5:0] a, input logic [3:0] be,
                       input logic [35:0] d, input logic oe, input int hold);
    @(posedge i_clk);
    #2;
    o_qual_n = (hold == 1);
    o_sleep = (hold == 2);
    if (hold == 0) begin
      o_wd = pw ? pend : ~o_wd;
      // An advance keeps the burst's kind, so a write burst sends data on every beat.
      if (k != 3) mop = k;
      pw = (mop == 2);
      pend = d;
      o_ctl = sdpc_pkg::sdpc_ctl_t'(codes[k]);
      o_addr = a;
      o_be_n = be;
      o_oe_n = oe;
    end
  endtask : issue
endmodule : sdpc_ctrl_model

`default_nettype wire

// File: testbench/sdpc_port_test.sv
// Self-checking bench for the SRAM port control with a behavioural memory.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end

module sdpc_port_test;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic mode = 1'b0;
  sdpc_pkg::sdpc_ctl_t ctl;
  logic [5:0] addr, a, base = 6'h0;
  logic [3:0] be_n, par;
  logic oe_n, qual_n, slp, dq_oe, par_oe, sleeping, pdesel = 1'b1, poe = 1'b0;
  logic [31:0] dq;
  logic [35:0] wd, pin, m [64];
  logic [36:0] sv;
  logic [1:0] beat = 2'h0;
  int bad_count = 0;
  int comparisons = 0;
  int op = 0, ph = 0;
  int dk [3] = '{0, 4, 5};
  ////////////////////////////////////////////////////////////
  // The pin level is the port's value while it drives, else the controller's.
  initial forever #12.5 i_clk = ~i_clk;
  assign pin = dq_oe ? {par, dq} : wd;
  sdpc_ctrl_model u_pm (.i_clk(i_clk), .o_ctl(ctl), .o_addr(addr), .o_be_n(be_n),
    .o_oe_n(oe_n), .o_qual_n(qual_n), .o_sleep(slp), .o_wd(wd));
  sdpc_port #(.ADDR_W(6), .LANES(4)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_ctl(ctl),
    .i_byte_write_select_n(be_n), .i_addr(addr), .i_clock_qualify_n(qual_n),
    .i_output_enable_n(oe_n), .i_sleep_request(slp), .i_burst_mode(mode),
    .i_dq(pin[31:0]), .i_parity_lanes(pin[35:32]), .o_dq(dq), .o_dq_oe(dq_oe),
    .o_parity_lanes(par), .o_parity_oe(par_oe), .o_sleeping(sleeping));
  // One command per edge; outputs are checked against the previous command.
  task automatic go(input int k, input logic [5:0] ad, input logic [3:0] be, input int hold);
    logic [35:0] d;
    logic [1:0] lo;
    logic en;
    logic o;
    d = 36'({$urandom, $urandom});
    o = ($urandom % 4 == 0);
    u_pm.issue(k, ad, be, d, o, hold);
    lo = mode ? base[1:0] ^ beat : base[1:0] + beat;
    en = op == 1 && !pdesel && !poe;
    if (ph == 2) `CHK("sleep", {sleeping, dq_oe}, 2'h2)
    else if (ph == 1) `CHK("hold", {dq_oe, par, dq}, sv)
    else begin
      `CHK("awake", sleeping, 1'b0)
      `CHK("drive", {dq_oe, par_oe}, {en, en})
      if (en) `CHK("data", {par, dq}, m[{base[5:2], lo}])
    end
    if (hold == 0) begin
      pdesel = (op == 0);
      poe = o;
      if (k == 3) beat++;
      else begin
        op = (k == 1) ? 1 : (k == 2) ? 2 : 0;
        base = ad;
        beat = 2'h0;
      end
      // A write, or each beat of a write burst, lands on its selected lanes.
      lo = mode ? base[1:0] ^ beat : base[1:0] + beat;
      if (op == 2) for (int i = 0; i < 4; i++) if (!be[i]) begin
        m[{base[5:2], lo}][8*i+:8] = d[8*i+:8];
        m[{base[5:2], lo}][32+i] = d[32+i];
      end
    end
    sv = {dq_oe, par, dq};
    ph = hold;
  endtask : go
  // Prints the counts and the verdict, then stops.
  task automatic wrap_up;
    $display("compared %0d, mismatched %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // Main sequence: fill, byte writes, bursts in both orders, freeze, sleep.
  initial begin
    void'($urandom(63));
    repeat (12) @(posedge i_clk);
    #2;
    i_rst = 1'b0;
    for (int i = 0; i < 64; i++) go(2, 6'(i), 4'h0, 0);
    go(0, 6'h0, 4'hf, 0);
    $display("test fill done");
    for (int i = 0; i < 12; i++) begin
      a = 6'($urandom);
      go(2, a, 4'($urandom), 0);
      go(dk[i % 3], a, 4'hf, 0);
      go(1, a, 4'hf, 0);
      go(1, a, 4'hf, 0);
    end
    $display("test byte writes done");
    for (int md = 0; md < 2; md++) begin
      mode = md[0];
      for (int j = 0; j < 4; j++) begin
        go(1, 6'($urandom), 4'hf, 0);
        repeat (5) go(3, 6'($urandom), 4'($urandom), 0);
        go(1, 6'($urandom), 4'hf, 0);
        go(0, 6'h0, 4'hf, 0);
        a = 6'($urandom);
        go(2, a, 4'($urandom), 0);
        repeat (3) go(3, 6'($urandom), 4'($urandom), 0);
        go(1, a, 4'hf, 0);
        repeat (3) go(3, a, 4'hf, 0);
        go(0, 6'h0, 4'hf, 0);
      end
    end
    $display("test bursts done");
    go(1, 6'h05, 4'hf, 0);
    go(1, 6'h2a, 4'hf, 0);
    repeat (3) go(1, 6'h11, 4'hf, 1);
    go(1, 6'h12, 4'hf, 0);
    go(0, 6'h0, 4'hf, 0);
    $display("test freeze done");
    go(0, 6'h0, 4'hf, 2);
    go(0, 6'h0, 4'hf, 0);
    go(0, 6'h0, 4'hf, 0);
    $display("test sleep done");
    wrap_up();
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    #(25 * 5000);
    bad_count++;
    wrap_up();
  end
endmodule : sdpc_port_test

`default_nettype wire
